// *** rtl/tws_slave_tx.sv ***
// Purpose: Slave transmitter of a byte-oriented two-wire serial interface
// Assumes: hclk 25 MHz; bus clock far slower, sampled through synchronisers
// Notes:   Master and slave receiver modes and bus error are not built
//
// The address map and the AHB-Lite register port were chosen for this implementation.
module tws_slave_tx
#(
   parameter int BUF_DEPTH = 2,
   parameter int BUF_WIDTH = 8
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire tws_pkg::tws_pin_s pad_in,
   output tws_pkg::tws_pad_s pad_out,
   output logic wake_req
);
   import tws_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam logic [PW:0] BUF_FULL = (PW + 1)'(BUF_DEPTH);

   logic [7:0] own_r, ctrl_r, code_r, rx_byte_r, shreg_r;
   logic [1:0] psc_r, slp_r;
   logic done_r, last_r, ack_r, wake_r, sda_oe_r, scl_oe_r, scl_wait_r;
   logic [3:0] cnt_r;
   tws_state_e state_r;
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic dph_valid_r, dph_write_r;
   logic [7:0] dph_addr_r;
   logic [BUF_WIDTH-1:0] buf_mem [BUF_DEPTH];
   logic [PW-1:0] wr_ptr_r, rd_ptr_r;
   logic [PW:0] buf_cnt_r;
   logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
   logic wr_en, hw_set, sw_clr, addr_ok, go_tx;
   logic [7:0] stat_code, rd_mux;

   function automatic logic addr_match(input logic [7:0] rx,
                                       input logic [7:0] own);
      // Address zero is only ever a general call, even with own address 0
      addr_match = (rx[7:1] == own[7:1] && rx[7:1] != GC_ADDR)
         || (own[0] && rx[7:1] == GC_ADDR);
   endfunction : addr_match

   // ---------------------------------------------------------------
   // Pin synchronisers and bus condition detection
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end
      else
      begin
         scl_m <= pad_in.scl;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= pad_in.sda;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign start_c = scl_s && scl_d && sda_d && !sda_s;
   assign stop_c = scl_s && scl_d && !sda_d && sda_s;

   // ---------------------------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dph_valid_r <= 1'b0;
         dph_write_r <= 1'b0;
         dph_addr_r <= 8'h00;
      end
      else if (hready)
      begin
         dph_valid_r <= hsel && htrans[1];
         dph_write_r <= hwrite;
         dph_addr_r <= haddr[7:0];
      end
   end

   // A data write into a full buffer stalls the bus instead of dropping it
   assign buf_in_valid = dph_valid_r && dph_write_r && dph_addr_r == OFS_DATA;
   assign hreadyout = !(buf_in_valid && !buf_in_ready);
   assign hresp = 1'b0;
   assign wr_en = dph_valid_r && dph_write_r && hreadyout;
   assign sw_clr = wr_en && dph_addr_r == OFS_CTRL && hwdata[CTRL_DONE];

   assign stat_code = done_r ? code_r : ST_NONE;

   always_comb
   begin
      unique case (dph_addr_r)
         OFS_OWN: rd_mux = own_r;
         OFS_CTRL: rd_mux = {done_r, ctrl_r[6:0]};
         OFS_STAT: rd_mux = {stat_code[7:3], 1'b0, psc_r};
         OFS_DATA: rd_mux = rx_byte_r;
         OFS_SLEEP: rd_mux = {6'h00, slp_r};
         default: rd_mux = 8'h00;
      endcase
   end

   assign hrdata = (dph_valid_r && !dph_write_r) ? {24'h000000, rd_mux}
                                                 : 32'h00000000;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         own_r <= OWN_RST;
         ctrl_r <= CTRL_RST;
         psc_r <= PSC_RST;
      end
      else if (wr_en)
      begin
         if (dph_addr_r == OFS_OWN)
            own_r <= hwdata[7:0];
         if (dph_addr_r == OFS_CTRL)
            ctrl_r <= {1'b0, hwdata[6:0]};
         if (dph_addr_r == OFS_STAT)
            psc_r <= hwdata[1:0];
      end
   end

   // Arbitration-lost marker is consumed by the address match it qualifies
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         slp_r <= SLP_RST;
      else if (wr_en && dph_addr_r == OFS_SLEEP)
         slp_r <= hwdata[1:0];
      else if (hw_set && state_r == S_ADDR_ACK)
         slp_r[SLP_ARB] <= 1'b0;
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         done_r <= 1'b0;
      else if (hw_set)
         done_r <= 1'b1;
      else if (sw_clr)
         done_r <= 1'b0;
   end

   // Wake request holds until software leaves deep sleep
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wake_r <= 1'b0;
      else if (!slp_r[SLP_DEEP])
         wake_r <= 1'b0;
      else if (addr_ok)
         wake_r <= 1'b1;
   end

   assign wake_req = wake_r;

   // ---------------------------------------------------------------
   // Two-entry transmit buffer
   // ---------------------------------------------------------------
   assign buf_in_ready = buf_cnt_r != BUF_FULL;
   assign buf_out_valid = buf_cnt_r != '0;
   assign buf_out_ready = go_tx;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         buf_cnt_r <= '0;
      end
      else
      begin
         if (buf_in_valid && buf_in_ready)
            wr_ptr_r <= (wr_ptr_r == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         if (buf_out_valid && buf_out_ready)
            rd_ptr_r <= (rd_ptr_r == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         buf_cnt_r <= buf_cnt_r + (PW + 1)'(buf_in_valid && buf_in_ready)
                    - (PW + 1)'(buf_out_valid && buf_out_ready);
      end
   end

   always_ff @(posedge hclk)
   begin
      if (buf_in_valid && buf_in_ready)
         buf_mem[wr_ptr_r] <= hwdata[BUF_WIDTH-1:0];
   end

   // ---------------------------------------------------------------
   // Bus protocol engine
   // ---------------------------------------------------------------
   // Enable and ack enable gate recognition; cleared ack enable isolates
   assign addr_ok = state_r == S_ADDR && scl_fall && cnt_r == ADDR_BITS
      && ctrl_r[CTRL_EN] && ctrl_r[CTRL_ACK_EN]
      && shreg_r[0] && addr_match(shreg_r, own_r);
   assign go_tx = state_r == S_WAIT && !done_r && buf_out_valid;
   assign hw_set = (state_r == S_ADDR_ACK && scl_fall)
      || (state_r == S_TX_ACK && scl_fall);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r <= S_IDLE;
         cnt_r <= 4'h0;
         shreg_r <= BYTE_RST;
         last_r <= 1'b0;
         ack_r <= 1'b0;
         code_r <= ST_NONE;
      end
      else if (stop_c)
         state_r <= S_IDLE;
      else if (start_c)
      begin
         state_r <= S_ADDR;
         cnt_r <= 4'h0;
      end
      else
      begin
         unique case (state_r)
            S_IDLE: ;
            S_ADDR:
            begin
               if (scl_rise)
               begin
                  shreg_r <= {shreg_r[6:0], sda_s};
                  cnt_r <= cnt_r + 4'h1;
               end
               else if (scl_fall && cnt_r == ADDR_BITS)
                  state_r <= addr_ok ? S_ADDR_ACK : S_IGNORE;
            end
            S_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  state_r <= S_WAIT;
                  code_r <= slp_r[SLP_ARB] ? ST_ARB_READ
                                           : ST_OWN_READ;
               end
            end
            S_WAIT:
            begin
               if (go_tx)
               begin
                  shreg_r <= buf_mem[rd_ptr_r];
                  last_r <= !ctrl_r[CTRL_ACK_EN];
                  cnt_r <= 4'h0;
                  state_r <= S_TX;
               end
            end
            S_TX:
            begin
               if (scl_fall)
               begin
                  if (cnt_r == LAST_BIT)
                     state_r <= S_TX_ACK;
                  else
                  begin
                     shreg_r <= {shreg_r[6:0], 1'b1};
                     cnt_r <= cnt_r + 4'h1;
                  end
               end
            end
            S_TX_ACK:
            begin
               if (scl_rise)
                  ack_r <= !sda_s;
               else if (scl_fall)
               begin
                  if (!ack_r)
                  begin
                     code_r <= ST_TX_NACK;
                     state_r <= S_IGNORE;
                  end
                  else if (last_r)
                  begin
                     code_r <= ST_LAST_ACK;
                     state_r <= S_IGNORE;
                  end
                  else
                  begin
                     code_r <= ST_TX_ACK;
                     state_r <= S_WAIT;
                  end
               end
            end
            S_IGNORE: ;
         endcase
      end
   end

   // Received address byte is kept only while awake; after a wake match
   // software must not expect it here
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rx_byte_r <= BYTE_RST;
      else if (addr_ok && !slp_r[SLP_DEEP])
         rx_byte_r <= shreg_r;
   end

   // SDA lags the state by one cycle, SCL release by two; far below a bus clock half period
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sda_oe_r <= 1'b0;
         scl_oe_r <= 1'b0;
         scl_wait_r <= 1'b0;
      end
      else
      begin
         sda_oe_r <= state_r == S_ADDR_ACK
            || (state_r == S_TX && !shreg_r[7]);
         // SCL goes free a cycle after SDA carries the first bit; the other
         // order shows SDA falling under a high SCL, a false START
         scl_wait_r <= state_r == S_WAIT;
         scl_oe_r <= state_r == S_WAIT || scl_wait_r;
      end
   end

   assign pad_out = '{scl_o: 1'b0, scl_oe: scl_oe_r,
                      sda_o: 1'b0, sda_oe: sda_oe_r};

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_status_no_flag: assert property (!done_r |-> stat_code == ST_NONE)
      else $error("status not 0xf8 without pending flag");
   a_status_psc_zero: assert property (stat_code[2:0] == 3'h0)
      else $error("status code has nonzero prescaler bits");
   a_addr_flag_set: assert property (state_r == S_ADDR_ACK && scl_fall |=> done_r && state_r == S_WAIT && (code_r == ST_OWN_READ || code_r == ST_ARB_READ))
      else $error("address ack did not raise flag with status");
   a_arb_lost_code: assert property (state_r == S_ADDR_ACK && scl_fall && slp_r[SLP_ARB] && !stop_c && !start_c |=> code_r == ST_ARB_READ)
      else $error("lost arbitration entry not reported as 0xb0");
   a_last_byte_end: assert property (state_r == S_TX_ACK && scl_fall && last_r && !stop_c && !start_c |=> state_r == S_IGNORE && (code_r == ST_TX_NACK || code_r == ST_LAST_ACK))
      else $error("last byte did not end in not addressed state");
   a_last_ack_code: assert property (state_r == S_TX_ACK && scl_fall && last_r && ack_r && !stop_c && !start_c |=> code_r == ST_LAST_ACK)
      else $error("acked last byte not reported as 0xc8");
   a_ignore_released: assert property (state_r == S_IGNORE ##1 state_r == S_IGNORE |-> !sda_oe_r)
      else $error("sda driven after last byte");
   a_isolate_addr: assert property (state_r == S_ADDR && scl_fall && cnt_r == ADDR_BITS && !ctrl_r[CTRL_ACK_EN] |=> state_r != S_ADDR_ACK)
      else $error("address answered with ack enable clear");
   a_wake_on_match: assert property (addr_ok && slp_r[SLP_DEEP] && !(wr_en && dph_addr_r == OFS_SLEEP) |=> wake_r)
      else $error("address match in deep sleep did not wake");
   a_scl_held: assert property (state_r == S_WAIT && done_r ##1 state_r == S_WAIT && done_r |-> scl_oe_r)
      else $error("scl not held while flag pending");
   a_ack_data_code: assert property (state_r == S_TX_ACK && scl_fall && !last_r && ack_r && !stop_c && !start_c |=> code_r == ST_TX_ACK && done_r)
      else $error("acked data byte not reported as 0xb8");
   a_msb_first: assert property (state_r == S_TX ##1 state_r == S_TX |-> sda_oe_r == !$past(shreg_r[7]))
      else $error("sda does not follow shift register msb");

endmodule : tws_slave_tx

// *** rtl/tws_pkg.sv ***
// Purpose: Shared constants and carriers for the two-wire slave transmitter
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   Status codes carry the prescaler field as zero
package tws_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_OWN = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;
   localparam logic [7:0] OFS_SLEEP = 8'h10;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_DONE = 7;
   localparam int CTRL_ACK_EN = 6;
   localparam int CTRL_STA = 5;
   localparam int CTRL_STO = 4;
   localparam int CTRL_EN = 2;
   localparam int SLP_DEEP = 0;
   localparam int SLP_ARB = 1;
   localparam logic [7:0] OWN_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] PSC_RST = 2'h0;
   localparam logic [1:0] SLP_RST = 2'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [3:0] ADDR_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [6:0] GC_ADDR = 7'h00;

   // ---------------------------------------------------------------
   // Status codes
   // ---------------------------------------------------------------
   localparam logic [7:0] ST_OWN_READ = 8'ha8;
   localparam logic [7:0] ST_ARB_READ = 8'hb0;
   localparam logic [7:0] ST_TX_ACK = 8'hb8;
   localparam logic [7:0] ST_TX_NACK = 8'hc0;
   localparam logic [7:0] ST_LAST_ACK = 8'hc8;
   localparam logic [7:0] ST_NONE = 8'hf8;

   typedef enum logic [2:0] {
      S_IDLE,
      S_ADDR,
      S_ADDR_ACK,
      S_WAIT,
      S_TX,
      S_TX_ACK,
      S_IGNORE
   } tws_state_e;

   // Levels seen on the open-drain bus wires
   typedef struct packed {
      logic scl;
      logic sda;
   } tws_pin_s;

   // Open-drain drive: output value and enable for each wire
   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } tws_pad_s;

endpackage : tws_pkg

// *** bench/tws_master_model.sv ***
// Purpose: Behavioural master receiver on the two-wire bus
// Assumes: Open-drain wires with pull-ups; a pull output high drives low
// Notes:   SCL stands still between frames; a stretched SCL is waited on
module tws_master_model
(
   input wire logic scl,
   input wire logic sda,
   output logic scl_pull,
   output logic sda_pull
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam time HALF = 160ns;

   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end

   // ---------------------------------------------------------------
   // Bus conditions and bit cycles
   // ---------------------------------------------------------------
   task automatic wait_scl;
      int n;
      n = 0;
      while (scl !== 1'b1 && n < 20000)
      begin
         #10;
         n++;
      end
   endtask : wait_scl

   // Nonblocking drive keeps a pin change off the edge the slave samples
   task automatic start;
      sda_pull <= 1'b1;
      #(HALF);
      scl_pull <= 1'b1;
   endtask : start

   // SDA moves only mid-low, so the slave never sees a false START or STOP
   task automatic bit_cyc(input logic v, output logic s);
      #(HALF / 2);
      sda_pull <= ~v;
      #(HALF / 2);
      scl_pull <= 1'b0;
      wait_scl();
      #(HALF);
      s = sda;
      scl_pull <= 1'b1;
   endtask : bit_cyc

   task automatic stop;
      #(HALF / 2);
      sda_pull <= 1'b1;
      #(HALF / 2);
      scl_pull <= 1'b0;
      wait_scl();
      #(HALF);
      sda_pull <= 1'b0;
      #(HALF);
   endtask : stop

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_cyc(b[i], s);
      bit_cyc(1'b1, s);
      ack = ~s;
   endtask : send_byte

   task automatic recv_byte(input logic mack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_cyc(1'b1, b[i]);
      bit_cyc(~mack, s);
   endtask : recv_byte
endmodule : tws_master_model

// *** bench/test_two_wire_slave_transmitter.sv ***
// Purpose: Self-checking bench of the two-wire slave transmitter
// Assumes: One AHB-Lite master; software is played by the bench
// Notes:   A write into a full data buffer is not forced, it would stall the bus for good
module test_two_wire_slave_transmitter import tws_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   tws_pin_s pin;
   tws_pad_s pad;
   logic wake_req;
   logic m_scl;
   logic m_sda;
   int n_mismatch;
   int tests_run;

   assign pin = {~(m_scl | pad.scl_oe), ~(m_sda | pad.sda_oe)};

   tws_slave_tx uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .pad_in(pin), .pad_out(pad),
      .wake_req(wake_req));
   tws_master_model m (.scl(pin.scl), .sda(pin.sda), .scl_pull(m_scl),
      .sda_pull(m_sda));

   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do
         @(posedge hclk);
      while (hreadyout !== 1'b1 && ++n < 2000);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do
         @(posedge hclk);
      while (hreadyout !== 1'b1 && ++n < 2000);
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0, "response not okay");
      if (n >= 2000)
         chk(32'h0, 32'h1, "bus hang");
   endtask : ahb

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      ahb(1'b1, a, {24'h0, d}, r);
   endtask : reg_wr

   task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(r, {24'h0, e}, "register");
   endtask : reg_chk

   task automatic wait_flag;
      logic [31:0] r;
      int n;
      n = 0;
      do
         ahb(1'b0, OFS_CTRL, 32'h0, r);
      while (r[CTRL_DONE] !== 1'b1 && ++n < 200);
      chk(r & 32'h80, 32'h80, "flag not set");
   endtask : wait_flag

   task automatic addr(input logic [7:0] b, input logic e);
      logic ack;
      m.start();
      m.send_byte(b, ack);
      chk({31'h0, ack}, {31'h0, e}, "address ack");
   endtask : addr

   task automatic rx_chk(input logic [7:0] c, input logic mack,
      input logic [7:0] d, input logic [7:0] st);
      logic [7:0] got;
      reg_wr(OFS_CTRL, c);
      m.recv_byte(mack, got);
      chk({24'h0, got}, {24'h0, d}, "data byte");
      wait_flag();
      reg_chk(OFS_STAT, st);
   endtask : rx_chk

   task automatic finish_read(input logic [7:0] d);
      wait_flag();
      reg_wr(OFS_DATA, d);
      rx_chk(8'h84, 1'b0, d, ST_TX_NACK);
      m.stop();
      reg_wr(OFS_CTRL, 8'hc4);
   endtask : finish_read

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      reg_chk(OFS_OWN, OWN_RST);
      reg_chk(OFS_CTRL, CTRL_RST);
      reg_chk(OFS_STAT, ST_NONE);
      reg_wr(8'h14, 8'h5a);
      reg_chk(8'h14, 8'h00);
      reg_wr(OFS_STAT, 8'h03);
      reg_chk(OFS_STAT, ST_NONE | 8'h03);
      reg_wr(OFS_STAT, 8'h00);
      $display("test reset done");
   endtask : t_reset

   // Two bytes wait in the buffer before the first goes on the wire
   task automatic t_burst;
      reg_wr(OFS_OWN, 8'ha4);
      reg_wr(OFS_CTRL, 8'h44);
      addr(8'ha5, 1'b1);
      wait_flag();
      reg_chk(OFS_STAT, ST_OWN_READ);
      reg_wr(OFS_DATA, 8'h9c);
      reg_wr(OFS_DATA, 8'h35);
      rx_chk(8'hc4, 1'b1, 8'h9c, ST_TX_ACK);
      reg_wr(OFS_DATA, 8'h6e);
      rx_chk(8'hc4, 1'b1, 8'h35, ST_TX_ACK);
      rx_chk(8'h84, 1'b0, 8'h6e, ST_TX_NACK);
      reg_wr(OFS_CTRL, 8'hc4);
      reg_chk(OFS_STAT, ST_NONE);
      m.stop();
      $display("test burst done");
   endtask : t_burst

   task automatic t_last_ack;
      logic [7:0] got;
      addr(8'ha5, 1'b1);
      wait_flag();
      reg_wr(OFS_DATA, 8'h81);
      rx_chk(8'h84, 1'b1, 8'h81, ST_LAST_ACK);
      m.recv_byte(1'b0, got);
      chk({24'h0, got}, 32'hff, "released data");
      m.stop();
      reg_wr(OFS_CTRL, 8'hc4);
      $display("test last ack done");
   endtask : t_last_ack

   task automatic t_match;
      logic [7:0] own_v [5] = '{8'ha4, 8'ha5, 8'ha4, 8'ha4, 8'h00};
      logic [7:0] adr [5] = '{8'h01, 8'h01, 8'h27, 8'ha4, 8'h01};
      logic ack [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < 5; i++)
      begin
         reg_wr(OFS_OWN, own_v[i]);
         addr(adr[i], ack[i]);
         if (ack[i])
            finish_read(8'h42);
         else
         begin
            reg_chk(OFS_STAT, ST_NONE);
            m.stop();
         end
      end
      $display("test match done");
   endtask : t_match

   task automatic t_isolate;
      reg_wr(OFS_OWN, 8'ha4);
      reg_wr(OFS_CTRL, 8'h04);
      addr(8'ha5, 1'b0);
      m.stop();
      reg_wr(OFS_CTRL, 8'h44);
      addr(8'ha5, 1'b1);
      finish_read(8'h17);
      $display("test isolate done");
   endtask : t_isolate

   task automatic t_arb;
      reg_wr(OFS_SLEEP, 8'h02);
      addr(8'ha5, 1'b1);
      wait_flag();
      reg_chk(OFS_STAT, ST_ARB_READ);
      reg_chk(OFS_SLEEP, 8'h00);
      finish_read(8'h3c);
      $display("test arbitration done");
   endtask : t_arb

   task automatic t_wake;
      reg_wr(OFS_SLEEP, 8'h01);
      addr(8'ha5, 1'b1);
      repeat (40) @(posedge hclk);
      @(negedge hclk);
      chk({31'h0, wake_req}, 32'h1, "no wake");
      chk({31'h0, pad.scl_oe}, 32'h1, "clock not held");
      reg_wr(OFS_SLEEP, 8'h00);
      finish_read(8'hd2);
      $display("test wake done");
   endtask : t_wake

   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_sim

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_burst();
      t_last_ack();
      t_match();
      t_isolate();
      t_arb();
      t_wake();
      end_sim();
   end

   // About 20 bytes at 3 us each plus register traffic fit well inside
   initial
   begin
      #2ms;
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim();
   end
endmodule : test_two_wire_slave_transmitter
